// ===== ledctl_pkg.sv
// constants shared by the led driver control latch files
package ledctl_pkg;
  localparam int SR_W = 49;
  localparam int CTL_W = 40;
  localparam int CHAN_N = 48;
  localparam int BC_W = 7;
  localparam int MC_W = 3;
  localparam logic [7:0] WRITE_CMD = 8'h96;
  // word layout
  localparam int TAG_BIT = 48;
  localparam int CMD_HI = 47;
  localparam int CMD_LO = 40;
  localparam int BC_R_LO = 0;
  localparam int BC_G_LO = 7;
  localparam int BC_B_LO = 14;
  localparam int MC_LO = 21;
  localparam int SEL_LO = 24;
  localparam int OPEN_LO = 26;
  localparam int SHORT_LO = 29;
  localparam int PSP_LO = 31;
  // reset values
  localparam logic [2:0] MC_RST = 3'h0;
  localparam logic [1:0] PSP_RST = 2'h3;
  // status select and power-save policy codes
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;
  localparam logic [1:0] PSP_NEVER = 2'h0;
  localparam logic [1:0] PSP_CLK_WAKE = 2'h1;
  typedef enum logic {LEDCTL_NORMAL, LEDCTL_SAVE} ledctl_ps_t;
endpackage : ledctl_pkg

// ===== ledctl_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ledctl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : ledctl_sync

// ===== ledctl_top.sv
// control latch, on/off latch and output gating of a 48-channel led driver
// What this block does
// - strobe edge copies low 33 bits when tag bit set and command is 96h
// - peak current changes only when same value written twice in a row
// - reset gives peak current 000b and power-save policy 11b
// - three 7-bit group brightness codes, red green blue
// - one 3-bit peak current code shared by all outputs
// - function bits pick readout, open and short thresholds, power save
// - separate 48-bit on/off latch, one bit per channel
// - blanking low drives channels whose on/off bit is one
// - blanking high forces every channel off
// - open and short flags read out through serial data out
// - select 01 loads open flags, 10 short flags, else nothing
// - policy 00 never saves; others save on all-zero on/off data
// - policy 01 wakes on serial clock edge, 10 on non-zero data
`timescale 1ns/1ps
module ledctl_top
  import ledctl_pkg::*;
#(
  parameter int CHANNELS = CHAN_N
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  input wire logic blank,
  input wire logic [CHANNELS-1:0] open_led_detect,
  input wire logic [CHANNELS-1:0] short_led_detect,
  output logic serial_data_out,
  output logic [CHANNELS-1:0] channel_output,
  output logic [MC_W-1:0] peak_current_code,
  output logic [BC_W-1:0] group_brightness_red,
  output logic [BC_W-1:0] group_brightness_green,
  output logic [BC_W-1:0] group_brightness_blue,
  output logic [1:0] status_readout_select,
  output logic [2:0] open_threshold_select,
  output logic [1:0] short_threshold_select,
  output logic [1:0] power_save_policy,
  output logic power_save_state
);
  // the word layout fixes the channel count, so refuse any other
  if (CHANNELS != CHAN_N) begin : g_chan_check
    $error("ledctl_top: word layout serves exactly 48 channels");
  end

  // ==========================================================
  // pin synchronisation and edge finding
  logic [3:0] pins_s;
  logic sclk_s, sdi_s, lat_s, blank_s;
  logic sclk_prev_q, lat_prev_q;
  logic sclk_rise, lat_rise;

  ledctl_sync #(.WIDTH(4)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({serial_clock, serial_data_in, latch_strobe, blank}),
    .sync_out(pins_s)
  );
  assign {sclk_s, sdi_s, lat_s, blank_s} = pins_s;

  // detector flags come from another domain and are synchronised as well
  logic [2*CHANNELS-1:0] flags_s;
  logic [CHANNELS-1:0] open_s, short_s;
  ledctl_sync #(.WIDTH(2 * CHANNELS)) u_flag_sync (
    .clock(clock),
    .rst(rst),
    .async_in({open_led_detect, short_led_detect}),
    .sync_out(flags_s)
  );
  assign {open_s, short_s} = flags_s;

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      lat_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      lat_prev_q <= lat_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign lat_rise = lat_s & ~lat_prev_q;

  // ==========================================================
  // shift register and strobed word decode
  logic [SR_W-1:0] sr_q, sr_d;
  logic cmd_ok, onoff_wr, onoff_zero;
  logic [MC_W-1:0] mc_in;

  assign cmd_ok = sr_q[TAG_BIT] && (sr_q[CMD_HI:CMD_LO] == WRITE_CMD);
  assign onoff_wr = lat_rise && !sr_q[TAG_BIT];
  assign onoff_zero = (sr_q[CHAN_N-1:0] == '0);
  assign mc_in = sr_q[MC_LO +: MC_W];

  // ==========================================================
  // control and on/off latches
  logic [MC_W-1:0] mc_q, mc_d, mc_prev_q, mc_prev_d;
  logic mc_prev_vld_q, mc_prev_vld_d;
  logic [BC_W-1:0] bc_r_q, bc_r_d, bc_g_q, bc_g_d, bc_b_q, bc_b_d;
  logic [1:0] sel_q, sel_d, short_q, short_d, psp_q, psp_d;
  logic [2:0] open_q, open_d;
  logic [CHANNELS-1:0] onoff_q, onoff_d, chan_q, chan_d;
  ledctl_ps_t ps_q, ps_d;

  // strobe loads status flags for readout, otherwise serial clock shifts
  always_comb begin
    sr_d = sr_q;
    if (lat_rise && sel_d == SEL_OPEN) begin
      sr_d = {1'b0, open_s};
    end else if (lat_rise && sel_d == SEL_SHORT) begin
      sr_d = {1'b0, short_s};
    end else if (sclk_rise) begin
      sr_d = {sr_q[SR_W-2:0], sdi_s}; // msb first
    end
  end

  // rejected words fall through with every field held
  always_comb begin
    mc_d = mc_q;
    mc_prev_d = mc_prev_q;
    mc_prev_vld_d = mc_prev_vld_q;
    bc_r_d = bc_r_q;
    bc_g_d = bc_g_q;
    bc_b_d = bc_b_q;
    sel_d = sel_q;
    open_d = open_q;
    short_d = short_q;
    psp_d = psp_q;
    onoff_d = onoff_q;
    if (lat_rise && cmd_ok) begin
      bc_r_d = sr_q[BC_R_LO +: BC_W];
      bc_g_d = sr_q[BC_G_LO +: BC_W];
      bc_b_d = sr_q[BC_B_LO +: BC_W];
      sel_d = sr_q[SEL_LO +: 2];
      open_d = sr_q[OPEN_LO +: 3];
      short_d = sr_q[SHORT_LO +: 2];
      psp_d = sr_q[PSP_LO +: 2];
      // a lone glitched write cannot move the current ceiling
      if (mc_prev_vld_q && mc_in == mc_prev_q) begin
        mc_d = mc_in;
      end
      mc_prev_d = mc_in;
      mc_prev_vld_d = 1'b1;
    end
    if (onoff_wr) begin
      onoff_d = sr_q[CHAN_N-1:0];
    end
  end

  // power-save entry and wake
  always_comb begin
    ps_d = ps_q;
    case (ps_q)
      LEDCTL_NORMAL: begin
        if (onoff_wr && onoff_zero && psp_q != PSP_NEVER) begin
          ps_d = LEDCTL_SAVE;
        end
      end
      LEDCTL_SAVE: begin
        if (psp_q == PSP_NEVER) begin
          ps_d = LEDCTL_NORMAL;
        end else if (psp_q == PSP_CLK_WAKE) begin
          if (sclk_rise) begin
            ps_d = LEDCTL_NORMAL;
          end
        end else if (onoff_wr && !onoff_zero) begin
          ps_d = LEDCTL_NORMAL;
        end
      end
      default: ps_d = LEDCTL_NORMAL;
    endcase
  end

  // blanking gates every channel; grey level is the controller's timing
  always_comb begin
    chan_d = blank_s ? '0 : onoff_q;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sr_q <= '0;
      mc_q <= MC_RST;
      mc_prev_q <= MC_RST;
      mc_prev_vld_q <= 1'b0;
      bc_r_q <= '0;
      bc_g_q <= '0;
      bc_b_q <= '0;
      sel_q <= '0;
      open_q <= '0;
      short_q <= '0;
      psp_q <= PSP_RST;
      onoff_q <= '0;
      chan_q <= '0;
      ps_q <= LEDCTL_NORMAL;
    end else begin
      sr_q <= sr_d;
      mc_q <= mc_d;
      mc_prev_q <= mc_prev_d;
      mc_prev_vld_q <= mc_prev_vld_d;
      bc_r_q <= bc_r_d;
      bc_g_q <= bc_g_d;
      bc_b_q <= bc_b_d;
      sel_q <= sel_d;
      open_q <= open_d;
      short_q <= short_d;
      psp_q <= psp_d;
      onoff_q <= onoff_d;
      chan_q <= chan_d;
      ps_q <= ps_d;
    end
  end

  assign serial_data_out = sr_q[SR_W-1];
  assign channel_output = chan_q;
  assign peak_current_code = mc_q;
  assign group_brightness_red = bc_r_q;
  assign group_brightness_green = bc_g_q;
  assign group_brightness_blue = bc_b_q;
  assign status_readout_select = sel_q;
  assign open_threshold_select = open_q;
  assign short_threshold_select = short_q;
  assign power_save_policy = psp_q;
  assign power_save_state = (ps_q == LEDCTL_SAVE);

  // ==========================================================
  // assertions
  sequence good_write_s;
    lat_rise && cmd_ok;
  endsequence
  // accepted write whose peak code repeats the previous accepted one
  sequence repeat_mc_s;
    good_write_s ##0 (mc_prev_vld_q && mc_in == mc_prev_q);
  endsequence
  sequence single_mc_s;
    good_write_s ##0 !(mc_prev_vld_q && mc_in == mc_prev_q);
  endsequence

  ctl_load_a: assert property (
    @(posedge clock) disable iff (rst)
    good_write_s |=> bc_g_q == $past(sr_q[BC_G_LO +: BC_W])
      && psp_q == $past(sr_q[PSP_LO +: 2]))
    else $error("control word not latched");
  reject_a: assert property (
    @(posedge clock) disable iff (rst)
    lat_rise && !cmd_ok |=> $stable(bc_r_q) && $stable(mc_q)
      && $stable(sel_q) && $stable(psp_q))
    else $error("rejected word altered control latch");
  mc_single_a: assert property (
    @(posedge clock) disable iff (rst)
    single_mc_s |=> $stable(mc_q))
    else $error("peak current moved on one write");
  mc_twice_a: assert property (
    @(posedge clock) disable iff (rst)
    repeat_mc_s |=> mc_q == $past(mc_in))
    else $error("peak current missed repeated write");
  reset_vals_a: assert property (
    @(posedge clock)
    rst |=> mc_q == MC_RST && psp_q == PSP_RST && !power_save_state)
    else $error("bad reset defaults");
  blank_off_a: assert property (
    @(posedge clock) disable iff (rst)
    blank_s |=> channel_output == '0)
    else $error("channel on while blanked");
  drive_on_a: assert property (
    @(posedge clock) disable iff (rst)
    !blank_s |=> channel_output == $past(onoff_q))
    else $error("channel not following on/off bit");
  shift_in_a: assert property (
    @(posedge clock) disable iff (rst)
    sclk_rise && !lat_rise |=> sr_q[0] == $past(sdi_s)
      && sr_q[SR_W-1:1] == $past(sr_q[SR_W-2:0]))
    else $error("shift register did not shift");
  open_load_a: assert property (
    @(posedge clock) disable iff (rst)
    lat_rise && sel_d == SEL_OPEN
      |=> sr_q[CHAN_N-1:0] == $past(open_s) && !serial_data_out)
    else $error("open flags not loaded");
  short_load_a: assert property (
    @(posedge clock) disable iff (rst)
    lat_rise && sel_d == SEL_SHORT
      |=> sr_q[CHAN_N-1:0] == $past(short_s) && !serial_data_out)
    else $error("short flags not loaded");
  save_enter_a: assert property (
    @(posedge clock) disable iff (rst)
    !power_save_state && onoff_wr && onoff_zero && psp_q != PSP_NEVER
      |=> power_save_state)
    else $error("power save not entered");
  clk_wake_a: assert property (
    @(posedge clock) disable iff (rst)
    power_save_state && psp_q == PSP_CLK_WAKE && sclk_rise
      |=> !power_save_state)
    else $error("no wake on serial clock");
  never_save_a: assert property (
    @(posedge clock) disable iff (rst)
    psp_q == PSP_NEVER |=> !power_save_state)
    else $error("power save under policy 00");
endmodule : ledctl_top

// ===== ledctl_ctrl_model.sv
// display controller model driving the serial pins of the led driver
`timescale 1ns/1ps
module ledctl_ctrl_model (
  input wire logic clock,
  output logic serial_clock,
  output logic serial_data_in,
  output logic latch_strobe,
  output logic blank
);
  // ==========================================================
  // pin driving
  // pins idle with the link clock still and all channels blanked
  initial begin
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
    blank = 1'b1;
  end

  // half of the 160 ns link period, counted in system cycles
  task automatic half_bit();
    repeat (10) @(negedge clock);
  endtask : half_bit

  // n low bits of w, msb first, one per rising serial clock edge
  task automatic shift(input logic [48:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      half_bit();
      serial_clock = 1'b1;
      half_bit();
      serial_clock = 1'b0;
    end
    serial_data_in = ~serial_data_in; // no stale value left after a frame
  endtask : shift

  // whole word then strobe; link clock kept still around the strobe edge
  task automatic send(input logic [48:0] w);
    shift(w, 49);
    half_bit();
    latch_strobe = 1'b1;
    half_bit();
    latch_strobe = 1'b0;
    half_bit();
  endtask : send

  // grey level comes from how long blank stays low
  task automatic set_blank(input logic v);
    blank = v;
  endtask : set_blank
endmodule : ledctl_ctrl_model

// ===== ledctl_top_test.sv
// self-checking testbench of the led driver control latch
`timescale 1ns/1ps
module ledctl_top_test;
  import ledctl_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic serial_clock, serial_data_in, latch_strobe, blank;
  logic [CHAN_N-1:0] open_led_detect = '0;
  logic [CHAN_N-1:0] short_led_detect = '0;
  logic serial_data_out, power_save_state;
  logic [CHAN_N-1:0] channel_output;
  logic [MC_W-1:0] peak_current_code;
  logic [BC_W-1:0] group_brightness_red, group_brightness_green;
  logic [BC_W-1:0] group_brightness_blue;
  logic [1:0] status_readout_select, short_threshold_select;
  logic [1:0] power_save_policy;
  logic [2:0] open_threshold_select;
  logic [48:0] w;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  // ==========================================================
  // clock, instances and run control
  always #4 clock = ~clock;

  ledctl_top #(.CHANNELS(CHAN_N)) DUT (
    .clock, .rst, .serial_clock, .serial_data_in, .latch_strobe, .blank,
    .open_led_detect, .short_led_detect, .serial_data_out,
    .channel_output, .peak_current_code, .group_brightness_red,
    .group_brightness_green, .group_brightness_blue,
    .status_readout_select, .open_threshold_select,
    .short_threshold_select, .power_save_policy, .power_save_state
  );

  ledctl_ctrl_model ctl (
    .clock, .serial_clock, .serial_data_in, .latch_strobe, .blank
  );

  // a hang costs at most this many cycles; the tests need about 25000
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // control word with fixed brightness and thresholds
  function automatic logic [48:0] cw(input logic [2:0] mc,
                                     input logic [1:0] sel,
                                     input logic [1:0] psp);
    return {1'b1, WRITE_CMD, 7'h00, psp, 2'h2, 3'h5, sel, mc,
            7'h33, 7'h22, 7'h11};
  endfunction : cw

  // ==========================================================
  // test sequence
  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    check("peak reset", MC_RST, peak_current_code);
    check("policy reset", PSP_RST, power_save_policy);
    ctl.send(cw(3'h5, 2'h0, 2'h0));
    check("red", 7'h11, group_brightness_red);
    check("green", 7'h22, group_brightness_green);
    check("blue", 7'h33, group_brightness_blue);
    check("open thr", 3'h5, open_threshold_select);
    check("short thr", 2'h2, short_threshold_select);
    check("policy", 2'h0, power_save_policy);
    check("peak once", MC_RST, peak_current_code);
    ctl.send(cw(3'h5, 2'h0, 2'h0));
    check("peak twice", 3'h5, peak_current_code);
    ctl.send({1'b1, 8'h95, 40'hff_ffff_ffff});
    check("bad cmd red", 7'h11, group_brightness_red);
    check("bad cmd policy", 2'h0, power_save_policy);
    check("bad cmd peak", 3'h5, peak_current_code);
    ctl.send(cw(3'h6, 2'h0, 2'h0));
    check("peak new once", 3'h5, peak_current_code);
    ctl.send(cw(3'h6, 2'h0, 2'h0));
    check("peak new twice", 3'h6, peak_current_code);
    // a repeat with another value between must not count as twice
    ctl.send(cw(3'h7, 2'h0, 2'h0));
    ctl.send(cw(3'h4, 2'h0, 2'h0));
    ctl.send(cw(3'h7, 2'h0, 2'h0));
    check("peak not adjacent", 3'h6, peak_current_code);
    // on/off data shows only while blank is low
    ctl.send({1'b0, 48'ha5a5_0f0f_8001});
    check("blanked", 48'h0, channel_output);
    ctl.set_blank(1'b0);
    repeat (8) @(negedge clock);
    check("driven", 48'ha5a5_0f0f_8001, channel_output);
    ctl.set_blank(1'b1);
    repeat (8) @(negedge clock);
    check("forced off", 48'h0, channel_output);
    // every select code: 01 and 10 load flags at the strobe, others keep the word, then shifted out
    open_led_detect = 48'h8000_0000_0000;
    short_led_detect = 48'h4000_0000_0000;
    for (int s = 0; s < 4; s++) begin
      ctl.send(cw(3'h6, s[1:0], 2'h0));
      w = (s == 1) ? {1'b0, open_led_detect} :
          (s == 2) ? {1'b0, short_led_detect} : cw(3'h6, s[1:0], 2'h0);
      check("select", s[1:0], status_readout_select);
      for (int k = 0; k < 3; k++) begin
        check("readout", w[48-k], serial_data_out);
        ctl.shift(49'h0, 1);
      end
    end
    // every power-save policy: sleep on all-zero data except under 00, then wake
    for (int p = 3; p >= 0; p--) begin
      ctl.send(cw(3'h6, 2'h0, p[1:0]));
      ctl.send({1'b0, 48'h0});
      check("save entered", p != 0, power_save_state);
      if (p == 1)
        ctl.shift(49'h0, 1);
      else
        ctl.send({1'b0, 48'h0000_0000_0100});
      repeat (6) @(negedge clock);
      check("woken", 1'b0, power_save_state);
    end
    check("peak kept", 3'h6, peak_current_code);
    // a second reset in mid-run must bring the defaults back
    rst = 1'b1;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    check("peak re-reset", MC_RST, peak_current_code);
    check("policy re-reset", PSP_RST, power_save_policy);
    finish_test();
  end
endmodule : ledctl_top_test
